// >>> inc/reset_monitor_pkg.sv
// Purpose: Shared constants for the reset-source monitor logic.
// Assumes: System clock of 10 MHz, synchronous active-high reset.
// Notes:   Field positions follow the control and flag byte layouts.
package reset_monitor_pkg;
    localparam int          CLOCK_HZ            = 10_000_000;
    localparam logic [7:0]  SETTLE_SELECT_RESET = 8'h05;
    localparam int          SETTLE_LOG2_PERIODS = 16;
    localparam int          SETTLE_CYCLES       = 1 << SETTLE_LOG2_PERIODS;
    localparam int          CM_ENABLE_BIT       = 0;
    localparam int          FLAG_CLOCK_MON_BIT  = 1;
    localparam int          FLAG_LOW_VOLT_BIT   = 0;
    localparam logic [7:0]  FLAGS_RESET         = 8'h00;
    localparam int          LV_ON_BIT           = 7;
    localparam int          LV_RESET_SEL_BIT    = 1;
    localparam int          LV_FLAG_BIT         = 0;
    localparam logic [7:0]  LV_CONTROL_RESET    = 8'h00;
    localparam logic [7:0]  LV_LEVEL_RESET      = 8'h00;
    localparam logic [7:0]  LV_LEVEL_MASK       = 8'h0f;
endpackage : reset_monitor_pkg

// >>> inc/settle_if.sv
// Purpose: Carries the settle counter status to the monitor logic.
// Assumes: One clock domain.
// Notes:   Done is a level that stays high once reached, until restart or reset.
`timescale 1ns/1ns
interface settle_if;
    logic restart;
    logic done;
    modport counter (input restart, output done);
    modport user    (output restart, input done);
endinterface : settle_if

// >>> verilog/osc_settle_counter.sv
// Purpose: Counts the oscillation stabilisation interval.
// Assumes: Synchronous active-high reset.
// Notes:   Restart reloads the count from zero.
`timescale 1ns/1ns
module osc_settle_counter #(
    parameter int SETTLE_CYCLES = reset_monitor_pkg::SETTLE_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst,
    settle_if.counter st
);
    localparam int W = $clog2(SETTLE_CYCLES + 1);
    logic [W-1:0] count_reg;
    logic         done_reg;

    if (SETTLE_CYCLES < 1) begin : g_bad_settle
        $error("settle count must be positive");
    end

    always_ff @(posedge clk) begin
        if (rst || st.restart) begin
            count_reg <= '0;
            done_reg  <= 1'b0;
        end else if (!done_reg) begin
            count_reg <= count_reg + W'(1);
            done_reg  <= (count_reg == W'(SETTLE_CYCLES - 1));
        end
    end
    assign st.done = done_reg;
endmodule : osc_settle_counter

// >>> verilog/reset_source_monitor_logic.sv
// Purpose: Reset-source control: clock monitor, power-on clear, low voltage.
// Assumes: Inputs synchronous to clk; writes are one-cycle strobes.
// Notes:   Internal reset is a one-cycle pulse raised by a monitor source.
`timescale 1ns/1ns
module reset_source_monitor_logic #(
    parameter int SETTLE_CYCLES = reset_monitor_pkg::SETTLE_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       power_on_clear,
    input  wire logic       rc_oscillator_sel,
    input  wire logic       osc_clock_lost,
    input  wire logic       supply_low,
    input  wire logic       cm_write,
    input  wire logic [7:0] cm_wdata,
    input  wire logic       lv_write,
    input  wire logic [7:0] lv_wdata,
    input  wire logic       lv_bit_clear,
    input  wire logic       level_write,
    input  wire logic [7:0] level_wdata,
    input  wire logic       low_voltage_irq_mask,
    output logic            clock_monitor_enable_bit,
    output logic [7:0]      reset_cause_flags,
    output logic [7:0]      low_voltage_control,
    output logic [7:0]      low_voltage_level_select,
    output logic            internal_reset,
    output logic            low_voltage_irq,
    output logic            clock_switch_ok,
    output logic            clock_monitor_active
);
    logic cm_reset;
    logic lv_reset;
    logic lv_reset_mode;
    logic lv_on;
    logic clear_all;
    logic prev_low_reg;
    logic lv_event;
    logic cm_rst_q_reg;
    settle_if st ();

    osc_settle_counter #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_settle (
        .clk (clk),
        .rst (rst),
        .st  (st)
    );
    // Settling restarts after any reset so the monitor waits again.
    assign st.restart = internal_reset || power_on_clear;

    assign lv_on         = low_voltage_control[reset_monitor_pkg::LV_ON_BIT];
    assign lv_reset_mode =
        low_voltage_control[reset_monitor_pkg::LV_RESET_SEL_BIT];
    // Edge on supply_low, so enabling reset mode on a good supply is quiet.
    assign lv_event  = lv_on && supply_low && !prev_low_reg;
    assign lv_reset  = lv_event && lv_reset_mode;
    assign cm_reset  = clock_monitor_active && osc_clock_lost
                       && !cm_rst_q_reg;
    assign clear_all = rst || power_on_clear;

    always_ff @(posedge clk) begin
        if (clear_all) prev_low_reg <= 1'b0;
        else prev_low_reg <= lv_on && supply_low;
    end

    always_ff @(posedge clk) begin
        if (clear_all) cm_rst_q_reg <= 1'b0;
        else cm_rst_q_reg <= cm_reset;
    end

    // Enable is set-only from software; cleared only by reset sources.
    always_ff @(posedge clk) begin
        if (clear_all || cm_reset || internal_reset) begin
            clock_monitor_enable_bit <= 1'b0;
        end else if (cm_write
                     && cm_wdata[reset_monitor_pkg::CM_ENABLE_BIT]) begin
            clock_monitor_enable_bit <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (clear_all) clock_monitor_active <= 1'b0;
        else clock_monitor_active <= clock_monitor_enable_bit
                                     && st.done;
    end

    // RC oscillator needs no settling wait before the clock switch.
    always_ff @(posedge clk) begin
        if (clear_all) clock_switch_ok <= 1'b0;
        else clock_switch_ok <= rc_oscillator_sel || st.done;
    end

    always_ff @(posedge clk) begin
        if (clear_all) internal_reset <= 1'b0;
        else internal_reset <= cm_reset || lv_reset;
    end

    // Power-on clear and rst empty the flags; flags otherwise only set here.
    always_ff @(posedge clk) begin
        if (power_on_clear) begin
            reset_cause_flags <= reset_monitor_pkg::FLAGS_RESET;
        end else if (rst) begin
            reset_cause_flags <= reset_monitor_pkg::FLAGS_RESET;
        end else begin
            if (cm_reset)
                reset_cause_flags[reset_monitor_pkg::FLAG_CLOCK_MON_BIT]
                    <= 1'b1;
            if (lv_reset)
                reset_cause_flags[reset_monitor_pkg::FLAG_LOW_VOLT_BIT]
                    <= 1'b1;
        end
    end

    // Detector state ignores internal_reset, so its own reset keeps it.
    always_ff @(posedge clk) begin
        if (clear_all) begin
            low_voltage_control <= reset_monitor_pkg::LV_CONTROL_RESET;
        end else begin
            if (lv_write) low_voltage_control <= lv_wdata;
            else if (lv_bit_clear)
                low_voltage_control[reset_monitor_pkg::LV_ON_BIT]
                    <= 1'b0;
            if (!lv_write)
                low_voltage_control[reset_monitor_pkg::LV_FLAG_BIT]
                    <= lv_on && supply_low;
        end
    end

    // Reserved upper bits are held at zero whatever software writes.
    always_ff @(posedge clk) begin
        if (clear_all)
            low_voltage_level_select <= reset_monitor_pkg::LV_LEVEL_RESET;
        else if (level_write)
            low_voltage_level_select <= level_wdata
                & reset_monitor_pkg::LV_LEVEL_MASK;
    end

    // Interrupt on each detection when unmasked, in either mode.
    always_ff @(posedge clk) begin
        if (clear_all) low_voltage_irq <= 1'b0;
        else low_voltage_irq <= lv_event && !low_voltage_irq_mask;
    end

    property p_cm_reset_clears;
        @(posedge clk) disable iff (rst)
        cm_reset && !power_on_clear |=> !clock_monitor_enable_bit
            && reset_cause_flags[1] && internal_reset;
    endproperty
    a_cm_reset_clears: assert property (p_cm_reset_clears)
        else $error("clock monitor reset did not clear enable or set flag");

    property p_rc_switch;
        @(posedge clk) disable iff (rst)
        rc_oscillator_sel && !power_on_clear |=> clock_switch_ok;
    endproperty
    a_rc_switch: assert property (p_rc_switch)
        else $error("rc clock switch not allowed");

    property p_settle_gate;
        @(posedge clk) disable iff (rst)
        clock_monitor_active |-> $past(st.done);
    endproperty
    a_settle_gate: assert property (p_settle_gate)
        else $error("clock monitor active before settling");

    property p_poc_clear;
        @(posedge clk) disable iff (rst)
        power_on_clear |=> reset_cause_flags == 8'h00;
    endproperty
    a_poc_clear: assert property (p_poc_clear)
        else $error("power-on clear left flags set");

    property p_lv_stop;
        @(posedge clk) disable iff (rst)
        (lv_write && lv_wdata == 8'h00) || (lv_bit_clear && !lv_write)
            |=> !low_voltage_control[7];
    endproperty
    a_lv_stop: assert property (p_lv_stop)
        else $error("detector not stopped");

    property p_level_reserved;
        @(posedge clk) disable iff (rst)
        low_voltage_level_select[7:4] == 4'h0;
    endproperty
    a_level_reserved: assert property (p_level_reserved)
        else $error("reserved level bits set");

    property p_no_reset_good_supply;
        @(posedge clk) disable iff (rst)
        !supply_low && !cm_reset |=> !internal_reset;
    endproperty
    a_no_reset_good_supply: assert property (p_no_reset_good_supply)
        else $error("reset raised with good supply");

    property p_irq_unmasked;
        @(posedge clk) disable iff (rst)
        lv_event && !low_voltage_irq_mask && !power_on_clear
            |=> low_voltage_irq;
    endproperty
    a_irq_unmasked: assert property (p_irq_unmasked)
        else $error("unmasked detection gave no interrupt");

    sequence s_enabled_quiet;
        clock_monitor_enable_bit && !cm_reset && !internal_reset
            && !power_on_clear;
    endsequence
    property p_enable_sticky;
        @(posedge clk) disable iff (rst)
        s_enabled_quiet |=> clock_monitor_enable_bit;
    endproperty
    a_enable_sticky: assert property (p_enable_sticky)
        else $error("software cleared clock monitor enable");

    property p_lv_keeps_state;
        @(posedge clk) disable iff (rst)
        internal_reset && !lv_write && !lv_bit_clear && !power_on_clear
            |=> low_voltage_control[7] == $past(low_voltage_control[7]);
    endproperty
    a_lv_keeps_state: assert property (p_lv_keeps_state)
        else $error("internal reset changed detector state");
endmodule : reset_source_monitor_logic

// >>> tb/reset_source_monitor_logic_tb.sv
// Purpose: Self-checking bench for the reset-source monitor logic.
// Assumes: Inputs change on the falling edge; outputs settle by then.
// Notes:   Settle count is shortened to keep the run brief.
`timescale 1ns/1ns
module reset_source_monitor_logic_tb;
    localparam int SETTLE = 8;
    logic       clk, rst, power_on_clear, rc_oscillator_sel;
    logic       osc_clock_lost, supply_low, low_voltage_irq_mask;
    logic       cm_write, lv_write, lv_bit_clear, level_write;
    logic [7:0] cm_wdata, lv_wdata, level_wdata, d;
    logic       clock_monitor_enable_bit, internal_reset, low_voltage_irq;
    logic       clock_switch_ok, clock_monitor_active;
    logic [7:0] reset_cause_flags, low_voltage_control;
    logic [7:0] low_voltage_level_select;
    int         error_cnt, compares;
    integer     seed;

    reset_source_monitor_logic #(.SETTLE_CYCLES(SETTLE)) dut (
        .clk, .rst, .power_on_clear, .rc_oscillator_sel, .osc_clock_lost,
        .supply_low, .cm_write, .cm_wdata, .lv_write, .lv_wdata,
        .lv_bit_clear, .level_write, .level_wdata, .low_voltage_irq_mask,
        .clock_monitor_enable_bit, .reset_cause_flags, .low_voltage_control,
        .low_voltage_level_select, .internal_reset, .low_voltage_irq,
        .clock_switch_ok, .clock_monitor_active);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One strobe per call; the register is visible when the task returns.
    // Strobes stay up until the next call or step, so back-to-back writes
    // never drop and raise a strobe within one time step.
    task automatic wr(input int which, input logic [7:0] val);
        cm_wdata = val;
        lv_wdata = val;
        level_wdata = val;
        cm_write = (which == 0);
        lv_write = (which == 1);
        level_write = (which == 2);
        lv_bit_clear = (which == 3);
        @(negedge clk);
    endtask : wr

    task automatic step;
        {cm_write, lv_write, level_write, lv_bit_clear} = 4'h0;
        @(negedge clk);
    endtask : step

    task automatic print_verdict;
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    initial begin
        #(2000 * 100);
        error_cnt++;
        print_verdict();
    end

    initial begin
        seed = 90179;
        {power_on_clear, rc_oscillator_sel, osc_clock_lost, supply_low} = 4'h0;
        {cm_write, lv_write, level_write, lv_bit_clear} = 4'h0;
        {cm_wdata, lv_wdata, level_wdata} = 24'h0;
        low_voltage_irq_mask = 1'b0;
        rst = 1'b1;
        repeat (4) step();
        rst = 1'b0;
        step();
        check("flags", reset_cause_flags, 8'h00);
        check("lv control", low_voltage_control, 8'h00);
        check("enable", {7'h0, clock_monitor_enable_bit}, 8'h00);
        $display("test reset values done");
        wr(0, 8'h01);
        check("enable set", {7'h0, clock_monitor_enable_bit}, 8'h01);
        check("active early", {7'h0, clock_monitor_active}, 8'h00);
        repeat (4) wr(0, 8'($random(seed)) & 8'hfe);
        check("enable kept", {7'h0, clock_monitor_enable_bit}, 8'h01);
        repeat (SETTLE) step();
        check("active", {7'h0, clock_monitor_active}, 8'h01);
        $display("test clock monitor enable done");
        osc_clock_lost = 1'b1;
        step();
        osc_clock_lost = 1'b0;
        check("cm reset", {7'h0, internal_reset}, 8'h01);
        check("enable clr", {7'h0, clock_monitor_enable_bit}, 8'h00);
        check("flags cm", reset_cause_flags, 8'h02);
        step();
        check("reset pulse", {7'h0, internal_reset}, 8'h00);
        // The settle restart reaches the switch output one cycle later.
        step();
        check("switch wait", {7'h0, clock_switch_ok}, 8'h00);
        rc_oscillator_sel = 1'b1;
        step();
        step();
        check("switch rc", {7'h0, clock_switch_ok}, 8'h01);
        rc_oscillator_sel = 1'b0;
        repeat (SETTLE + 4) step();
        check("active off", {7'h0, clock_monitor_active}, 8'h00);
        $display("test clock monitor reset done");
        power_on_clear = 1'b1;
        step();
        power_on_clear = 1'b0;
        step();
        check("flags poc", reset_cause_flags, 8'h00);
        $display("test power-on clear done");
        wr(1, 8'h82);
        repeat (3) begin
            check("no reset", {7'h0, internal_reset}, 8'h00);
            step();
        end
        supply_low = 1'b1;
        step();
        check("lv reset", {7'h0, internal_reset}, 8'h01);
        check("lv irq", {7'h0, low_voltage_irq}, 8'h01);
        check("flags lv", reset_cause_flags, 8'h01);
        supply_low = 1'b0;
        step();
        check("irq pulse", {7'h0, low_voltage_irq}, 8'h00);
        // Its own reset has acted now; the detector setup must survive it.
        check("lv kept", low_voltage_control, 8'h82);
        low_voltage_irq_mask = 1'b1;
        supply_low = 1'b1;
        step();
        check("irq masked", {7'h0, low_voltage_irq}, 8'h00);
        supply_low = 1'b0;
        step();
        $display("test low voltage reset done");
        wr(3, 8'h00);
        check("on cleared", low_voltage_control & 8'h80, 8'h00);
        supply_low = 1'b1;
        step();
        check("stopped", {7'h0, internal_reset}, 8'h00);
        supply_low = 1'b0;
        wr(1, 8'h82);
        wr(1, 8'h00);
        check("byte stop", low_voltage_control, 8'h00);
        $display("test detector stop done");
        repeat (8) begin
            d = 8'($random(seed));
            wr(2, d);
            check("level", low_voltage_level_select, d & 8'h0f);
        end
        $display("test level select done");
        print_verdict();
    end
endmodule : reset_source_monitor_logic_tb
